// ### verilog/ccp_regs.svh
`ifndef CCP_REGS_SVH
`define CCP_REGS_SVH

// --------------------------------------------------
// register byte offsets
// --------------------------------------------------
`define CCP_CTRL_OFF 8'h00
`define CCP_CMP_OFF 8'h04
`define CCP_WIDTH_OFF 8'h08
`define CCP_CAPT_OFF 8'h0c
`define CCP_STAT_OFF 8'h10
`define CCP_MASK_OFF 8'h14

// --------------------------------------------------
// channel_control fields
// --------------------------------------------------
`define CCP_EN_BIT 7
`define CCP_OUT_BIT 5
`define CCP_ALIGN_BIT 4
`define CCP_MODE_HI 3
`define CCP_MODE_LO 0

// --------------------------------------------------
// reset values
// --------------------------------------------------
`define CCP_CTRL_RESET 8'h00
`define CCP_STAT_RESET 1'b0
`define CCP_MASK_RESET 1'b0

// --------------------------------------------------
// edge counts for the prescaled captures
// --------------------------------------------------
`define CCP_EDGES_DIV4 5'h04
`define CCP_EDGES_DIV16 5'h10

`endif

// ### verilog/ccp_pkg.sv
package ccp_pkg;

  // --------------------------------------------------
  // mode selector codes
  // --------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OFF = 4'h0,
    MODE_TOGGLE_CLR = 4'h1,
    MODE_TOGGLE = 4'h2,
    MODE_CAP_EVERY = 4'h3,
    MODE_CAP_FALL = 4'h4,
    MODE_CAP_RISE = 4'h5,
    MODE_CAP_RISE4 = 4'h6,
    MODE_CAP_RISE16 = 4'h7,
    MODE_SET = 4'h8,
    MODE_CLEAR = 4'h9,
    MODE_PULSE = 4'ha,
    MODE_PULSE_CLR = 4'hb
  } mode_t;

  // --------------------------------------------------
  // operating class, one-hot
  // --------------------------------------------------
  typedef enum logic [3:0] {
    OP_OFF = 4'b0001,
    OP_CAPTURE = 4'b0010,
    OP_COMPARE = 4'b0100,
    OP_PWM = 4'b1000
  } op_class_t;

endpackage

// ### verilog/edge_prescaler.sv
`timescale 1ns/1ps
`include "ccp_regs.svh"

module edge_prescaler (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic restart,
  input wire logic rise,
  input wire logic fall,
  input wire logic [3:0] mode,
  output logic fire
);

  // --------------------------------------------------
  // edge selection
  // --------------------------------------------------
  logic [4:0] count_reg;
  logic [4:0] count_next;
  logic [4:0] need;
  logic [4:0] count_inc;
  logic counted;

  assign need = (mode == ccp_pkg::MODE_CAP_RISE16) ? `CCP_EDGES_DIV16 : `CCP_EDGES_DIV4;
  assign counted = (mode == ccp_pkg::MODE_CAP_RISE4) || (mode == ccp_pkg::MODE_CAP_RISE16);
  assign count_inc = count_reg + 5'h01;

  always_comb begin
    fire = 1'b0;
    count_next = count_reg;
    if (restart) begin
      count_next = 5'h00;
    end else if (counted) begin
      if (rise) begin
        fire = (count_inc == need);
        count_next = fire ? 5'h00 : count_inc;
      end
    end else begin
      unique case (mode)
        ccp_pkg::MODE_CAP_EVERY: fire = rise | fall;
        ccp_pkg::MODE_CAP_FALL: fire = fall;
        ccp_pkg::MODE_CAP_RISE: fire = rise;
        default: fire = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 5'h00;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

endmodule

// ### verilog/capture_compare_pwm_control.sv
`timescale 1ns/1ps
`include "ccp_regs.svh"

// What this block does
// - channel runs only while enable bit is set, fully idle otherwise
// - control bit 5 reads back the output level; writes ignore it
// - control bits 3..0 select the mode; 0000 disables the channel
// - modes 11xx are pwm; alignment bit 1 left, 0 right, pwm only
// - 1010 pulses output on match; 1011 also clears the timer
// - 1000 sets, 1001 clears on match; level resets when off
// - 0010 toggles on match; 0001 toggles and clears the timer
// - the timer cleared is whichever timer feeds this channel
// - 0111 captures on every sixteenth rising input edge
// - 0110 captures on every fourth rising input edge
// - 0101 captures on every rising input edge
// - 0100 captures on every falling input edge
// - 0011 captures on every input edge

module capture_compare_pwm_control #(
  parameter int TIMER_W = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [TIMER_W-1:0] associated_timer,
  input wire logic timer_period_match,
  output logic timer_clear,
  input wire logic channel_pin_in,
  output logic channel_pin_out,
  output logic channel_pin_oe,
  output logic irq
);

  // --------------------------------------------------
  // operating class of a mode code
  // --------------------------------------------------
  function automatic ccp_pkg::op_class_t op_of(input logic [3:0] mode);
    ccp_pkg::op_class_t op;
    op = ccp_pkg::OP_OFF;
    unique case (mode[3:2])
      2'b11: op = ccp_pkg::OP_PWM;
      2'b10: op = ccp_pkg::OP_COMPARE;
      2'b01: op = ccp_pkg::OP_CAPTURE;
      2'b00: begin
        if (mode == ccp_pkg::MODE_CAP_EVERY) begin
          op = ccp_pkg::OP_CAPTURE;
        end else if (mode == ccp_pkg::MODE_OFF) begin
          op = ccp_pkg::OP_OFF;
        end else begin
          op = ccp_pkg::OP_COMPARE;
        end
      end
    endcase
    return op;
  endfunction

  // --------------------------------------------------
  // state
  // --------------------------------------------------
  logic en_reg;
  logic align_reg;
  logic [3:0] mode_reg;
  logic [TIMER_W-1:0] compare_reg;
  logic [TIMER_W-1:0] width_reg;
  logic [TIMER_W-1:0] capture_reg;
  logic stat_reg;
  logic stat_next;
  logic mask_reg;
  logic out_reg;
  logic out_next;
  logic oe_reg;
  logic clear_reg;
  logic irq_reg;
  logic pin_prev_reg;
  logic eq_prev_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;

  // --------------------------------------------------
  // bus decode
  // --------------------------------------------------
  wire addr_take = hsel && htrans[1] && hready;
  wire wr_ctrl = wr_pend_reg && (addr_reg == `CCP_CTRL_OFF);
  wire wr_cmp = wr_pend_reg && (addr_reg == `CCP_CMP_OFF);
  wire wr_width = wr_pend_reg && (addr_reg == `CCP_WIDTH_OFF);
  wire wr_stat = wr_pend_reg && (addr_reg == `CCP_STAT_OFF);
  wire wr_mask = wr_pend_reg && (addr_reg == `CCP_MASK_OFF);

  wire [7:0] ctrl_view = {en_reg, 1'b0, out_reg, align_reg, mode_reg};
  wire [31:0] rd_data =
    (addr_reg == `CCP_CTRL_OFF) ? {24'h000000, ctrl_view} :
    (addr_reg == `CCP_CMP_OFF) ? {{(32-TIMER_W){1'b0}}, compare_reg} :
    (addr_reg == `CCP_WIDTH_OFF) ? {{(32-TIMER_W){1'b0}}, width_reg} :
    (addr_reg == `CCP_CAPT_OFF) ? {{(32-TIMER_W){1'b0}}, capture_reg} :
    (addr_reg == `CCP_STAT_OFF) ? {31'h00000000, stat_reg} :
    (addr_reg == `CCP_MASK_OFF) ? {31'h00000000, mask_reg} :
    32'h00000000;

  // --------------------------------------------------
  // channel decode
  // --------------------------------------------------
  ccp_pkg::op_class_t op;
  assign op = op_of(mode_reg);
  wire active = en_reg && (op != ccp_pkg::OP_OFF);
  wire is_cmp = active && (op == ccp_pkg::OP_COMPARE);
  wire is_cap = active && (op == ccp_pkg::OP_CAPTURE);
  wire is_pwm = active && (op == ccp_pkg::OP_PWM);

  wire rise = channel_pin_in && !pin_prev_reg;
  wire fall = !channel_pin_in && pin_prev_reg;

  // match only on first cycle of equality, so a stalled timer fires once
  wire eq_now = (associated_timer == compare_reg);
  wire match = is_cmp && eq_now && !eq_prev_reg;

  wire clear_mode = (mode_reg == ccp_pkg::MODE_TOGGLE_CLR) ||
    (mode_reg == ccp_pkg::MODE_PULSE_CLR);

  // right alignment saturates when width exceeds the period
  wire [TIMER_W-1:0] right_start = (width_reg >= compare_reg) ?
    '0 : compare_reg - width_reg;
  wire pwm_left = associated_timer < width_reg;
  wire pwm_right = associated_timer >= right_start;
  wire pwm_level = align_reg ? pwm_left : pwm_right;
  wire pwm_event = is_pwm && timer_period_match;

  // --------------------------------------------------
  // capture edge selection
  // --------------------------------------------------
  logic cap_raw;
  edge_prescaler u_prescaler (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .restart(!is_cap || wr_ctrl),
    .rise(rise),
    .fall(fall),
    .mode(mode_reg),
    .fire(cap_raw)
  );
  wire cap_fire = is_cap && cap_raw;

  wire chan_event = cap_fire || match || pwm_event;

  // --------------------------------------------------
  // output level
  // --------------------------------------------------
  always_comb begin
    out_next = out_reg;
    if (!active) begin
      out_next = 1'b0;
    end else if (is_pwm) begin
      out_next = pwm_level;
    end else if (is_cmp) begin
      unique case (mode_reg)
        ccp_pkg::MODE_SET: out_next = match ? 1'b1 : out_reg;
        ccp_pkg::MODE_CLEAR: out_next = match ? 1'b0 : out_reg;
        ccp_pkg::MODE_PULSE,
        ccp_pkg::MODE_PULSE_CLR: out_next = match;
        ccp_pkg::MODE_TOGGLE,
        ccp_pkg::MODE_TOGGLE_CLR: out_next = out_reg ^ match;
        default: out_next = out_reg;
      endcase
    end
  end

  // set wins over a same-cycle write-one clear
  assign stat_next = chan_event || (stat_reg && !(wr_stat && hwdata[0]));

  // --------------------------------------------------
  // control register
  // --------------------------------------------------
  // one reset word, sliced per field, so the fields cannot drift apart
  localparam logic [7:0] CTRL_RST = `CCP_CTRL_RESET;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      en_reg <= CTRL_RST[`CCP_EN_BIT];
      align_reg <= CTRL_RST[`CCP_ALIGN_BIT];
      mode_reg <= CTRL_RST[`CCP_MODE_HI:`CCP_MODE_LO];
    end else if (ce && wr_ctrl) begin
      en_reg <= hwdata[`CCP_EN_BIT];
      align_reg <= hwdata[`CCP_ALIGN_BIT];
      mode_reg <= hwdata[`CCP_MODE_HI:`CCP_MODE_LO];
    end
  end

  // --------------------------------------------------
  // compare and width registers
  // --------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      compare_reg <= '0;
    end else if (ce && wr_cmp) begin
      compare_reg <= hwdata[TIMER_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      width_reg <= '0;
    end else if (ce && wr_width) begin
      width_reg <= hwdata[TIMER_W-1:0];
    end
  end

  // --------------------------------------------------
  // capture register
  // --------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      capture_reg <= '0;
    end else if (ce && cap_fire) begin
      capture_reg <= associated_timer;
    end
  end

  // --------------------------------------------------
  // event status, mask, interrupt
  // --------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stat_reg <= `CCP_STAT_RESET;
    end else if (ce) begin
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= `CCP_MASK_RESET;
    end else if (ce && wr_mask) begin
      mask_reg <= hwdata[0];
    end
  end

  // mask and status are read as next values so irq tracks them in step
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= stat_next && (wr_mask ? hwdata[0] : mask_reg);
    end
  end

  // --------------------------------------------------
  // pin side
  // --------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_prev_reg <= 1'b0;
      eq_prev_reg <= 1'b0;
    end else if (ce) begin
      pin_prev_reg <= channel_pin_in;
      eq_prev_reg <= eq_now;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (ce) begin
      out_reg <= out_next;
      oe_reg <= active && (op != ccp_pkg::OP_CAPTURE);
    end
  end

  // pulse to whatever timer is wired to this channel
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clear_reg <= 1'b0;
    end else if (ce) begin
      clear_reg <= match && clear_mode;
    end
  end

  // --------------------------------------------------
  // ahb-lite data phase
  // --------------------------------------------------
  // reads take one wait state so a write just before is seen
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else if (ce) begin
      wr_pend_reg <= addr_take && hwrite;
      rd_pend_reg <= addr_take && !hwrite;
      if (addr_take) begin
        addr_reg <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h00000000;
    end else if (ce) begin
      if (addr_take && !hwrite) begin
        hreadyout_reg <= 1'b0;
      end else if (rd_pend_reg) begin
        hreadyout_reg <= 1'b1;
        hrdata_reg <= rd_data;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hresp_reg <= 1'b0;
    end else if (ce) begin
      hresp_reg <= 1'b0;
    end
  end

  // --------------------------------------------------
  // outputs
  // --------------------------------------------------
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign timer_clear = clear_reg;
  assign channel_pin_out = out_reg;
  assign channel_pin_oe = oe_reg;
  assign irq = irq_reg;

endmodule

// ### tb/ccp_chk.sv
`timescale 1ns/1ps
module ccp_chk #(
  parameter int TIMER_W = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic timer_clear,
  input wire logic channel_pin_out,
  input wire logic channel_pin_oe
);
  // ------
  // control shadow, snooped off the bus
  // ------
  logic wr_reg;
  logic [7:0] ctl_reg;
  wire en = ctl_reg[7];
  wire [3:0] md = ctl_reg[3:0];
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg <= 1'b0;
      ctl_reg <= 8'h00;
    end else if (ce && hready) begin
      wr_reg <= hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00;
      if (wr_reg) begin
        ctl_reg <= hwdata[7:0];
      end
    end
  end
  // ------
  // properties
  // ------
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_pulse;
    channel_pin_out ##1 !channel_pin_out;
  endsequence
  // outputs lag the shadow by one edge, hence two samples
  property p_off; (!en || md == 4'h0) [*2] |-> !channel_pin_oe && !channel_pin_out; endproperty
  a_off: assert property (p_off) else $error("pin active while off");
  property p_cap; (en && md inside {[4'h3:4'h7]}) [*2] |-> !channel_pin_oe; endproperty
  a_cap: assert property (p_cap) else $error("pin driven in capture");
  property p_pwm; (en && md[3:2] == 2'b11) [*2] |-> channel_pin_oe; endproperty
  a_pwm: assert property (p_pwm) else $error("pin idle in pwm");
  property p_pulse; en && md[3:1] == 3'b101 && $rose(channel_pin_out) |-> s_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse not one cycle");
  property p_pclr; en && md == 4'hb && $rose(channel_pin_out) |-> timer_clear; endproperty
  a_pclr: assert property (p_pclr) else $error("pulse without clear");
  property p_set; (en && md == 4'h8) [*2] |-> !$fell(channel_pin_out); endproperty
  a_set: assert property (p_set) else $error("set level dropped");
  property p_clr; (en && md == 4'h9) [*2] |-> !$rose(channel_pin_out); endproperty
  a_clr: assert property (p_clr) else $error("clear level rose");
  property p_tog; (en && md == 4'h1) [*2] |-> $changed(channel_pin_out) == timer_clear; endproperty
  a_tog: assert property (p_tog) else $error("toggle and clear apart");
  property p_tcl; timer_clear |-> en && (md == 4'h1 || md == 4'hb) ##1 !timer_clear; endproperty
  a_tcl: assert property (p_tcl) else $error("stray timer clear");
endmodule

bind capture_compare_pwm_control ccp_chk #(.TIMER_W(TIMER_W)) i_chk (
  .clock(clock), .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .timer_clear(timer_clear),
  .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe));

// ### tb/timer_model.sv
`timescale 1ns/1ps
module timer_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic run,
  input wire logic timer_clear,
  input wire logic ext_level,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic [15:0] top,
  output logic [15:0] count,
  output logic period_match,
  output logic pin_in
);
  // pin reads back the channel while it drives
  assign pin_in = pin_oe ? pin_out : ext_level;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= 16'h0000;
      period_match <= 1'b0;
    end else begin
      // a lowered top wraps at once instead of running through the whole range
      period_match <= run && count >= top;
      if (timer_clear) begin
        count <= 16'h0000;
      end else if (run) begin
        count <= (count >= top) ? 16'h0000 : count + 16'h0001;
      end
    end
  end
endmodule

// ### tb/capture_compare_pwm_control_tb.sv
`timescale 1ns/1ps
module capture_compare_pwm_control_tb;
  logic clock, rst_b, ce, hsel, hwrite, hreadyout, hresp, timer_clear, pin_out, pin_oe, irq;
  logic pmatch, pin_in, run, ext, exp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [15:0] count, top, prev;
  logic [3:0] cm [6] = '{4'h8, 4'h9, 4'h2, 4'h1, 4'ha, 4'hb};
  int err_total, n_tests, cyc, rc, k, c, w;
  // expected capture values, pushed when the model predicts a capture
  int unsigned cap_q[$];
  capture_compare_pwm_control i_dut (.clock(clock), .rst_b(rst_b), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .associated_timer(count), .timer_period_match(pmatch), .timer_clear(timer_clear),
    .channel_pin_in(pin_in), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .irq(irq));
  timer_model i_tmr (.clock(clock), .rst_b(rst_b), .run(run), .timer_clear(timer_clear),
    .ext_level(ext), .pin_out(pin_out), .pin_oe(pin_oe), .top(top), .count(count),
    .period_match(pmatch), .pin_in(pin_in));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  // ------
  // shared tasks
  // ------
  task chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  // ready is taken as sampled at the edge, before the slave updates it
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge clock iff hreadyout);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock iff hreadyout);
    q = hrdata;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ------
  // tests
  // ------
  initial begin
    rst_b = 1'b0;
    {hsel, hwrite, run, ext, htrans, haddr, hwdata} = '0;
    ce = 1'b1;
    top = 16'hffff;
    {cyc, err_total, n_tests} = '0;
    void'($urandom(32'hca250845));
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    for (k = 0; k < 7; k++) begin
      bus(1'b0, 8'(k * 4), 32'h0);
      chk(q, 32'h0);
      chk(hresp, 1'b0);
    end
    bus(1'b1, 8'h00, 32'h70);
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h10);
    bus(1'b1, 8'h14, 32'h1);
    $display("registers done");
    for (int m = 3; m < 8; m++) begin
      bus(1'b1, 8'h00, 32'h80 | m);
      rc = 0;
      for (int e = 0; e < 32; e++) begin
        run <= 1'b1;
        wait_n(1 + $urandom % 3);
        run <= 1'b0;
        ext <= ~ext;
        wait_n(4);
        if (ext) rc++;
        exp = m == 3 || (m == 4 && !ext) || (ext && (m == 5 || (m == 6 && rc % 4 == 0)
          || (m == 7 && rc % 16 == 0)));
        // timer is frozen while the pin moves, so its value is the one captured
        if (exp) cap_q.push_back(count);
        bus(1'b0, 8'h10, 32'h0);
        chk(q, exp);
        chk(irq, exp);
        if (exp) begin
          bus(1'b0, 8'h0c, 32'h0);
          chk(q, cap_q.pop_front());
          bus(1'b1, 8'h10, 32'h1);
        end
      end
      $display("capture mode %0d done", m);
    end
    top <= 16'd39;
    run <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      c = 5 + $urandom % 30;
      bus(1'b1, 8'h04, c);
      // enable right after a match, so the next one is a whole period away
      wait (count == 16'(c));
      // odd passes also set the alignment bit, which compare modes must ignore
      bus(1'b1, 8'h00, 32'h80 | cm[i] | (i % 2) * 16);
      for (int j = 1; j < 3; j++) begin
        k = 0;
        while (count !== 16'(c) && k < 100) begin
          wait_n(1);
          k++;
        end
        wait_n(1);
        exp = cm[i] == 8 || (cm[i] inside {1, 2} && j == 1) || cm[i] > 9;
        chk(pin_out, exp);
        chk(timer_clear, cm[i] == 1 || cm[i] == 11);
        chk(pin_oe, 1'b1);
        wait_n(1);
        if (cm[i] > 9) chk(pin_out, 1'b0);
        if (cm[i] == 1 || cm[i] == 11) chk(count, 16'h0000);
      end
      bus(1'b0, 8'h10, 32'h0);
      chk(q, 32'h1);
      bus(1'b1, 8'h10, 32'h1);
      bus(1'b1, 8'h00, i[0] ? 32'h80 : 32'(cm[i]));
      wait_n(2);
      chk({pin_out, pin_oe}, 2'b00);
      $display("compare mode %0d done", cm[i]);
    end
    bus(1'b1, 8'h14, 32'h0);
    w = 1 + $urandom % 18;
    bus(1'b1, 8'h04, 32'd20);
    bus(1'b1, 8'h08, w);
    top <= 16'd19;
    for (int m = 12; m < 16; m++) begin
      bus(1'b1, 8'h00, 32'h80 | m | ((m & 1) << 4));
      wait_n(2);
      for (k = 0; k < 60; k++) begin
        prev = count;
        wait_n(1);
        chk(pin_out, m[0] ? prev < w : prev >= 20 - w);
      end
      bus(1'b0, 8'h10, 32'h0);
      chk(q, 32'h1);
      chk(irq, 1'b0);
      bus(1'b1, 8'h10, 32'h1);
      $display("pwm mode %0d done", m);
    end
    // low clock enable: the pwm level must hold for a whole timer period
    ce <= 1'b0;
    wait_n(1);
    exp = pin_out;
    for (k = 0; k < 20; k++) begin
      wait_n(1);
      chk(pin_out, exp);
    end
    ce <= 1'b1;
    $display("clock enable hold done");
    bus(1'b1, 8'h00, 32'h0);
    wrap_up();
  end
endmodule
